// File: rbia_defines.svh
`ifndef RBIA_DEFINES_SVH
`define RBIA_DEFINES_SVH
// pointer geometry
`define RBIA_XPTR_W      23
`define RBIA_LOW_W       16
`define RBIA_HIGH_W      7
`define RBIA_NPTR        8
`define RBIA_PSEL_W      3
// target register file: 4 accumulators, 8 auxiliaries, 4 temporaries
`define RBIA_NTGT        16
`define RBIA_TSEL_W      4
`define RBIA_TGT_W       40
`define RBIA_ACC_BASE    4'h0
`define RBIA_AUX_BASE    4'h4
`define RBIA_TMP_BASE    4'hC
`define RBIA_AUX_W       16
`define RBIA_TMP_W       16
// pointer steps
`define RBIA_STEP_ONE    23'h000001
`define RBIA_STEP_TWO    23'h000002
`define RBIA_ADDR_ONE    16'h0001
// msb of the bit index inside a 40-bit target
`define RBIA_BIT_MSB     5
// reset values
`define RBIA_XPTR_RST    23'h000000
`define RBIA_TGT_RST     40'h0000000000
`endif

// File: rbia_pkg.sv
package rbia_pkg;
  // pointer addressing forms
  typedef enum logic [1:0] {
    RBIA_FORM_PLAIN,
    RBIA_FORM_POST_INC,
    RBIA_FORM_POST_DEC
  } rbia_form_type;
  // register-bit operations
  typedef enum logic [1:0] {
    RBIA_OP_SET,
    RBIA_OP_PAIR_TEST
  } rbia_op_type;
  // execution state
  typedef enum logic {
    RBIA_ST_IDLE,
    RBIA_ST_BUSY
  } rbia_state_type;
endpackage : rbia_pkg

// File: rbia_addr_gen.sv
`timescale 1ns/1ps
`include "rbia_defines.svh"
// bit address and pointer update from the current pointer value
module rbia_addr_gen (
  input  wire logic [`RBIA_XPTR_W-1:0]  xptr_in,        // current extended pointer
  input  wire logic [`RBIA_LOW_W-1:0]   bsa_in,         // buffer start offset
  input  wire logic                     circ_in,        // circular addressing selected
  input  wire rbia_pkg::rbia_form_type  form_in,        // addressing form
  input  wire logic                     pair_in,        // two-bit operation
  output logic      [`RBIA_LOW_W-1:0]   bit_addr_out,   // generated bit address
  output logic      [`RBIA_XPTR_W-1:0]  next_xptr_out   // updated extended pointer
);
  logic [`RBIA_XPTR_W-1:0] step;

  // address from low word, offset only when circular
  always_comb begin
    if (circ_in) begin
      bit_addr_out = xptr_in[`RBIA_LOW_W-1:0] + bsa_in; // [RULE_02] [RULE_12] [RULE_08]
    end else begin
      bit_addr_out = xptr_in[`RBIA_LOW_W-1:0]; // [RULE_02] [RULE_12]
    end
  end

  // step of 1 or 2 by operand width
  assign step = pair_in ? `RBIA_STEP_TWO : `RBIA_STEP_ONE; // [RULE_07] [RULE_09]

  // pointer modification after use
  always_comb begin
    unique case (form_in)
      rbia_pkg::RBIA_FORM_PLAIN:    next_xptr_out = xptr_in; // [RULE_03]
      rbia_pkg::RBIA_FORM_POST_INC: next_xptr_out = xptr_in + step; // [RULE_07]
      rbia_pkg::RBIA_FORM_POST_DEC: next_xptr_out = xptr_in - step; // [RULE_09] [RULE_10]
      default:                      next_xptr_out = xptr_in;
    endcase
  end
endmodule : rbia_addr_gen

// File: rbia_core.sv
`timescale 1ns/1ps
`include "rbia_defines.svh"
// Function
// RULE_01: pointer is 23 bits, 7-bit high part
// RULE_02: low 16 bits plus offset give address
// RULE_03: plain form leaves pointer unchanged
// RULE_04: bit set forces addressed target bit
// RULE_05: pair test reads address and address+1
// RULE_06: lower bit to flag one, upper flag two
// RULE_07: post-increment adds 1 or 2
// RULE_08: address uses pointer before its update
// RULE_09: post-decrement subtracts 1 or 2
// RULE_10: one-bit post-decrement reduces by one
// RULE_11: only accumulators, auxiliaries, temporaries targeted
// RULE_12: offset added only when circular selected
module rbia_core #(
  parameter int NPTR = `RBIA_NPTR,                       // number of pointers
  parameter int NTGT = `RBIA_NTGT                        // number of target registers
) (
  input  wire logic                     CLOCK_IN,        // cpu clock
  input  wire logic                     ARST_N_IN,       // async reset, active low
  input  wire logic                     EXEC_IN,         // instruction strobe, one cycle
  input  wire rbia_pkg::rbia_op_type    OP_IN,           // set or pair test
  input  wire rbia_pkg::rbia_form_type  FORM_IN,         // addressing form
  input  wire logic [`RBIA_PSEL_W-1:0]  PTR_SEL_IN,      // pointer select
  input  wire logic [`RBIA_TSEL_W-1:0]  TGT_SEL_IN,      // target register select
  input  wire logic                     CIRC_IN,         // circular mode for pointer
  input  wire logic [`RBIA_LOW_W-1:0]   BSA_IN,          // buffer start offset
  input  wire logic                     PTR_WR_IN,       // pointer load strobe
  input  wire logic [`RBIA_XPTR_W-1:0]  PTR_WDATA_IN,    // pointer load value
  input  wire logic                     TGT_WR_IN,       // target load strobe
  input  wire logic [`RBIA_TGT_W-1:0]   TGT_WDATA_IN,    // target load value
  input  wire logic [`RBIA_PSEL_W-1:0]  RD_PTR_SEL_IN,   // pointer readback select
  input  wire logic [`RBIA_TSEL_W-1:0]  RD_TGT_SEL_IN,   // target readback select
  output logic      [`RBIA_XPTR_W-1:0]  PTR_RDATA_OUT,   // pointer readback, registered
  output logic      [`RBIA_HIGH_W-1:0]  PTR_HIGH_OUT,    // high part of readback pointer
  output logic      [`RBIA_TGT_W-1:0]   TGT_RDATA_OUT,   // target readback, registered
  output logic      [`RBIA_LOW_W-1:0]   BIT_ADDR_OUT,    // last bit address, registered
  output logic                          FLAG1_OUT,       // first test flag
  output logic                          FLAG2_OUT,       // second test flag
  output logic                          DONE_OUT,        // execution done pulse
  output logic                          ILLEGAL_OUT      // out-of-range bit address pulse
);
  logic [`RBIA_XPTR_W-1:0] xptr [NPTR];                  // [RULE_01]
  logic [`RBIA_TGT_W-1:0]  tgt  [NTGT];                  // [RULE_11]
  logic [`RBIA_XPTR_W-1:0] cur_xptr;
  logic [`RBIA_XPTR_W-1:0] next_xptr;
  logic [`RBIA_LOW_W-1:0]  bit_addr;
  logic [`RBIA_LOW_W-1:0]  bit_addr_hi;
  logic [`RBIA_TGT_W-1:0]  cur_tgt;
  logic                    pair;
  logic                    in_range;
  logic                    first_bit;
  logic                    second_bit;

  // width of a target register by its class
  function automatic logic [`RBIA_LOW_W-1:0] tgt_width(input logic [`RBIA_TSEL_W-1:0] sel);
    if (sel < `RBIA_AUX_BASE) begin
      tgt_width = `RBIA_LOW_W'(`RBIA_TGT_W);
    end else if (sel < `RBIA_TMP_BASE) begin
      tgt_width = `RBIA_LOW_W'(`RBIA_AUX_W);
    end else begin
      tgt_width = `RBIA_LOW_W'(`RBIA_TMP_W);
    end
  endfunction : tgt_width

  // operand selection
  assign pair     = (OP_IN == rbia_pkg::RBIA_OP_PAIR_TEST);
  assign cur_xptr = xptr[PTR_SEL_IN];
  assign cur_tgt  = tgt[TGT_SEL_IN];

  rbia_addr_gen u_addr_gen (
    .xptr_in       (cur_xptr),
    .bsa_in        (BSA_IN),
    .circ_in       (CIRC_IN),
    .form_in       (FORM_IN),
    .pair_in       (pair),
    .bit_addr_out  (bit_addr),
    .next_xptr_out (next_xptr)
  );

  // second bit of a pair and range check against register width
  assign bit_addr_hi = bit_addr + `RBIA_ADDR_ONE; // [RULE_05]
  assign in_range = pair ? (bit_addr_hi < tgt_width(TGT_SEL_IN)) && (bit_addr_hi != '0)
                         : (bit_addr < tgt_width(TGT_SEL_IN)); // [RULE_11]
  assign first_bit  = in_range ? cur_tgt[bit_addr[`RBIA_BIT_MSB:0]] : 1'b0; // [RULE_05]
  assign second_bit = in_range ? cur_tgt[bit_addr_hi[`RBIA_BIT_MSB:0]] : 1'b0; // [RULE_05]

  // pointer file: load or post-modify after use
  generate
    for (genvar p = 0; p < NPTR; p++) begin : g_ptr
      always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
          xptr[p] <= `RBIA_XPTR_RST;
        end else if (EXEC_IN && (PTR_SEL_IN == p)) begin
          xptr[p] <= next_xptr; // [RULE_03] [RULE_07] [RULE_08] [RULE_09] [RULE_10]
        end else if (PTR_WR_IN && (PTR_SEL_IN == p)) begin
          xptr[p] <= PTR_WDATA_IN;
        end
      end
    end
  endgenerate

  // target file: load or bit set
  generate
    for (genvar t = 0; t < NTGT; t++) begin : g_tgt
      always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
          tgt[t] <= `RBIA_TGT_RST;
        end else if (EXEC_IN && !pair && in_range && (TGT_SEL_IN == t)) begin
          tgt[t][bit_addr[`RBIA_BIT_MSB:0]] <= 1'b1; // [RULE_04]
        end else if (TGT_WR_IN && (TGT_SEL_IN == t)) begin
          tgt[t] <= TGT_WDATA_IN;
        end
      end
    end
  endgenerate

  // test flags of status register zero
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      FLAG1_OUT <= 1'b0;
      FLAG2_OUT <= 1'b0;
    end else if (EXEC_IN && pair && in_range) begin
      FLAG1_OUT <= first_bit; // [RULE_06]
      FLAG2_OUT <= second_bit; // [RULE_06]
    end
  end

  // status pulses and last address
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      DONE_OUT     <= 1'b0;
      ILLEGAL_OUT  <= 1'b0;
      BIT_ADDR_OUT <= '0;
    end else begin
      DONE_OUT    <= EXEC_IN;
      ILLEGAL_OUT <= EXEC_IN && !in_range;
      if (EXEC_IN) begin
        BIT_ADDR_OUT <= bit_addr; // [RULE_08]
      end
    end
  end

  // registered readback
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      PTR_RDATA_OUT <= `RBIA_XPTR_RST;
      TGT_RDATA_OUT <= `RBIA_TGT_RST;
    end else begin
      PTR_RDATA_OUT <= xptr[RD_PTR_SEL_IN];
      TGT_RDATA_OUT <= tgt[RD_TGT_SEL_IN];
    end
  end

  // high part split of the readback pointer
  assign PTR_HIGH_OUT = PTR_RDATA_OUT[`RBIA_XPTR_W-1:`RBIA_LOW_W]; // [RULE_01]

  // checks
  chk_plain_keeps: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN) // [RULE_03]
    EXEC_IN && FORM_IN == rbia_pkg::RBIA_FORM_PLAIN |=> xptr[$past(PTR_SEL_IN)] == $past(cur_xptr))
    else $error("plain form changed pointer");
  chk_inc_step: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN) // [RULE_07]
    EXEC_IN && FORM_IN == rbia_pkg::RBIA_FORM_POST_INC
    |=> xptr[$past(PTR_SEL_IN)] == $past(cur_xptr) + ($past(pair) ? 23'h000002 : 23'h000001))
    else $error("post increment step wrong");
  chk_dec_step: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN) // [RULE_09]
    EXEC_IN && FORM_IN == rbia_pkg::RBIA_FORM_POST_DEC && pair
    |=> xptr[$past(PTR_SEL_IN)] == $past(cur_xptr) - 23'h000002)
    else $error("post decrement by two wrong");
  chk_dec_one: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN) // [RULE_10]
    EXEC_IN && FORM_IN == rbia_pkg::RBIA_FORM_POST_DEC && !pair
    |=> xptr[$past(PTR_SEL_IN)] == $past(cur_xptr) - 23'h000001)
    else $error("post decrement by one wrong");
  chk_addr_before: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN) // [RULE_08]
    EXEC_IN && !CIRC_IN |=> BIT_ADDR_OUT == $past(cur_xptr[15:0]))
    else $error("address not from old pointer");
  chk_circ_offset: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN) // [RULE_12]
    EXEC_IN && CIRC_IN |=> BIT_ADDR_OUT == 16'($past(cur_xptr[15:0]) + $past(BSA_IN)))
    else $error("circular offset wrong");
  chk_bit_set: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN) // [RULE_04]
    EXEC_IN && !pair && in_range
    |=> tgt[$past(TGT_SEL_IN)] == ($past(cur_tgt) | (40'h0000000001 << $past(bit_addr[5:0]))))
    else $error("bit set wrong");
  chk_pair_flags: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN) // [RULE_06]
    EXEC_IN && pair && in_range
    |=> FLAG1_OUT == $past(cur_tgt[bit_addr[5:0]]) && FLAG2_OUT == $past(cur_tgt[bit_addr_hi[5:0]]))
    else $error("pair test flags wrong");
  chk_range_flag: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN) // [RULE_11]
    EXEC_IN && !in_range |=> ILLEGAL_OUT && $stable(FLAG1_OUT))
    else $error("out of range not flagged");
  chk_high_part: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN) // [RULE_01]
    1'b1 |=> PTR_HIGH_OUT == $past(xptr[RD_PTR_SEL_IN][`RBIA_XPTR_W-1:`RBIA_LOW_W]))
    else $error("high part split wrong");
endmodule : rbia_core

// File: rbia_core_test.sv
`timescale 1ns/1ps
`include "rbia_defines.svh"
// self-checking bench for the register-bit indirect addressing core
module rbia_core_test;
  `define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_fail++; \
    $display("wrong value at %0t: compare mismatch", $time); end end
  logic                     CLOCK_IN, ARST_N_IN, EXEC_IN, CIRC_IN, PTR_WR_IN, TGT_WR_IN;
  rbia_pkg::rbia_op_type    OP_IN;
  rbia_pkg::rbia_form_type  FORM_IN;
  logic [`RBIA_PSEL_W-1:0]  PTR_SEL_IN, RD_PTR_SEL_IN;
  logic [`RBIA_TSEL_W-1:0]  TGT_SEL_IN, RD_TGT_SEL_IN;
  logic [`RBIA_LOW_W-1:0]   BSA_IN, BIT_ADDR_OUT;
  logic [`RBIA_XPTR_W-1:0]  PTR_WDATA_IN, PTR_RDATA_OUT;
  logic [`RBIA_TGT_W-1:0]   TGT_WDATA_IN, TGT_RDATA_OUT;
  logic [`RBIA_HIGH_W-1:0]  PTR_HIGH_OUT;
  logic                     FLAG1_OUT, FLAG2_OUT, DONE_OUT, ILLEGAL_OUT;
  int                       n_fail, checks_done, cycles;
  localparam logic [3:0]    accumulator_three = `RBIA_ACC_BASE + 4'h3;

  rbia_core dut (.CLOCK_IN(CLOCK_IN), .ARST_N_IN(ARST_N_IN), .EXEC_IN(EXEC_IN), .OP_IN(OP_IN),
    .FORM_IN(FORM_IN), .PTR_SEL_IN(PTR_SEL_IN), .TGT_SEL_IN(TGT_SEL_IN), .CIRC_IN(CIRC_IN),
    .BSA_IN(BSA_IN), .PTR_WR_IN(PTR_WR_IN), .PTR_WDATA_IN(PTR_WDATA_IN), .TGT_WR_IN(TGT_WR_IN),
    .TGT_WDATA_IN(TGT_WDATA_IN), .RD_PTR_SEL_IN(RD_PTR_SEL_IN), .RD_TGT_SEL_IN(RD_TGT_SEL_IN),
    .PTR_RDATA_OUT(PTR_RDATA_OUT), .PTR_HIGH_OUT(PTR_HIGH_OUT), .TGT_RDATA_OUT(TGT_RDATA_OUT),
    .BIT_ADDR_OUT(BIT_ADDR_OUT), .FLAG1_OUT(FLAG1_OUT), .FLAG2_OUT(FLAG2_OUT),
    .DONE_OUT(DONE_OUT), .ILLEGAL_OUT(ILLEGAL_OUT));

  // 20 MHz clock
  initial CLOCK_IN = 1'b0;
  always #25 CLOCK_IN = ~CLOCK_IN;

  // hang guard, well above the expected run length
  always @(posedge CLOCK_IN) begin
    cycles++;
    if (cycles == 2000) begin
      n_fail++;
      results();
    end
  end

  task automatic results;
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results

  // one-cycle load strobes
  task automatic wr_ptr(input logic [2:0] s, input logic [22:0] v);
    @(negedge CLOCK_IN);
    PTR_SEL_IN = s;
    PTR_WDATA_IN = v;
    PTR_WR_IN = 1'b1;
    @(negedge CLOCK_IN);
    PTR_WR_IN = 1'b0;
  endtask : wr_ptr

  task automatic wr_tgt(input logic [3:0] s, input logic [39:0] v);
    @(negedge CLOCK_IN);
    TGT_SEL_IN = s;
    TGT_WDATA_IN = v;
    TGT_WR_IN = 1'b1;
    @(negedge CLOCK_IN);
    TGT_WR_IN = 1'b0;
  endtask : wr_tgt

  // readback settles one cycle after the select
  task automatic rd(input logic [2:0] p, input logic [3:0] t);
    @(negedge CLOCK_IN);
    RD_PTR_SEL_IN = p;
    RD_TGT_SEL_IN = t;
    repeat (2) @(negedge CLOCK_IN);
  endtask : rd

  // one instruction, then a bounded wait for done
  task automatic exec(input rbia_pkg::rbia_op_type op, input rbia_pkg::rbia_form_type fm,
                      input logic [2:0] p, input logic [3:0] t);
    int k;
    @(negedge CLOCK_IN);
    OP_IN = op;
    FORM_IN = fm;
    PTR_SEL_IN = p;
    TGT_SEL_IN = t;
    EXEC_IN = 1'b1;
    @(negedge CLOCK_IN);
    EXEC_IN = 1'b0;
    k = 0;
    while (DONE_OUT !== 1'b1 && k < 3) begin
      @(negedge CLOCK_IN);
      k++;
    end
    `CHK(DONE_OUT, 1'b1)
  endtask : exec

  task automatic t_plain;
    wr_ptr(3'h2, 23'h7F0005);
    wr_tgt(accumulator_three, 40'h0000000000);
    exec(rbia_pkg::RBIA_OP_SET, rbia_pkg::RBIA_FORM_PLAIN, 3'h2, accumulator_three);
    `CHK(BIT_ADDR_OUT, 16'h0005)
    `CHK(ILLEGAL_OUT, 1'b0)
    rd(3'h2, accumulator_three);
    `CHK(PTR_RDATA_OUT, 23'h7F0005)
    `CHK(PTR_HIGH_OUT, 7'h7F)
    `CHK(TGT_RDATA_OUT, 40'h0000000020)
    $display("test plain done");
  endtask : t_plain

  task automatic t_pair;
    wr_ptr(3'h5, 23'h00001E);
    wr_tgt(accumulator_three, 40'h0240000000);
    exec(rbia_pkg::RBIA_OP_PAIR_TEST, rbia_pkg::RBIA_FORM_POST_INC, 3'h5, accumulator_three);
    `CHK(BIT_ADDR_OUT, 16'h001E)
    `CHK({FLAG1_OUT, FLAG2_OUT}, 2'h2)
    exec(rbia_pkg::RBIA_OP_PAIR_TEST, rbia_pkg::RBIA_FORM_POST_DEC, 3'h5, accumulator_three);
    `CHK(BIT_ADDR_OUT, 16'h0020)
    `CHK({FLAG1_OUT, FLAG2_OUT}, 2'h1)
    rd(3'h5, accumulator_three);
    `CHK(PTR_RDATA_OUT, 23'h00001E)
    `CHK(TGT_RDATA_OUT, 40'h0240000000)
    $display("test pair done");
  endtask : t_pair

  task automatic t_step1;
    wr_ptr(3'h1, 23'h000007);
    wr_tgt(`RBIA_AUX_BASE, 40'h0000000001);
    exec(rbia_pkg::RBIA_OP_SET, rbia_pkg::RBIA_FORM_POST_INC, 3'h1, `RBIA_AUX_BASE);
    `CHK(BIT_ADDR_OUT, 16'h0007)
    exec(rbia_pkg::RBIA_OP_SET, rbia_pkg::RBIA_FORM_POST_DEC, 3'h1, `RBIA_AUX_BASE);
    `CHK(BIT_ADDR_OUT, 16'h0008)
    rd(3'h1, `RBIA_AUX_BASE);
    `CHK(PTR_RDATA_OUT, 23'h000007)
    `CHK(TGT_RDATA_OUT, 40'h0000000181)
    $display("test single step done");
  endtask : t_step1

  task automatic t_circ;
    wr_ptr(3'h0, 23'h000003);
    wr_tgt(`RBIA_ACC_BASE, 40'h0000000000);
    @(negedge CLOCK_IN);
    CIRC_IN = 1'b1;
    BSA_IN = 16'h0010;
    exec(rbia_pkg::RBIA_OP_SET, rbia_pkg::RBIA_FORM_PLAIN, 3'h0, `RBIA_ACC_BASE);
    `CHK(BIT_ADDR_OUT, 16'h0013)
    rd(3'h0, `RBIA_ACC_BASE);
    `CHK(TGT_RDATA_OUT, 40'h0000080000)
    CIRC_IN = 1'b0;
    exec(rbia_pkg::RBIA_OP_SET, rbia_pkg::RBIA_FORM_PLAIN, 3'h0, `RBIA_ACC_BASE);
    `CHK(BIT_ADDR_OUT, 16'h0003)
    $display("test offset done");
  endtask : t_circ

  task automatic t_range;
    wr_ptr(3'h6, 23'h000010);
    wr_tgt(`RBIA_TMP_BASE, 40'h0000000000);
    exec(rbia_pkg::RBIA_OP_SET, rbia_pkg::RBIA_FORM_POST_INC, 3'h6, `RBIA_TMP_BASE);
    `CHK(ILLEGAL_OUT, 1'b1)
    rd(3'h6, `RBIA_TMP_BASE);
    `CHK(PTR_RDATA_OUT, 23'h000011)
    `CHK(TGT_RDATA_OUT, 40'h0000000000)
    wr_ptr(3'h6, 23'h00000F);
    exec(rbia_pkg::RBIA_OP_PAIR_TEST, rbia_pkg::RBIA_FORM_PLAIN, 3'h6, `RBIA_TMP_BASE);
    `CHK(ILLEGAL_OUT, 1'b1)
    `CHK({FLAG1_OUT, FLAG2_OUT}, 2'h1)
    $display("test range done");
  endtask : t_range

  // reset, then each scenario in turn
  initial begin
    {ARST_N_IN, EXEC_IN, CIRC_IN, PTR_WR_IN, TGT_WR_IN} = 5'h00;
    OP_IN = rbia_pkg::RBIA_OP_SET;
    FORM_IN = rbia_pkg::RBIA_FORM_PLAIN;
    {PTR_SEL_IN, RD_PTR_SEL_IN, TGT_SEL_IN, RD_TGT_SEL_IN, BSA_IN} = '0;
    PTR_WDATA_IN = '0;
    TGT_WDATA_IN = '0;
    n_fail = 0;
    checks_done = 0;
    cycles = 0;
    repeat (3) @(negedge CLOCK_IN);
    ARST_N_IN = 1'b1;
    rd(3'h2, accumulator_three);
    `CHK(PTR_RDATA_OUT, `RBIA_XPTR_RST)
    `CHK(TGT_RDATA_OUT, `RBIA_TGT_RST)
    t_plain();
    t_pair();
    t_step1();
    t_circ();
    t_range();
    results();
  end
endmodule : rbia_core_test
